// >>> design/frame_pkg.sv
/*
 * constants and types of the response frame builder.
 * assumes one byte stream toward the host serial port.
 */
package frame_pkg;

    // ****************
    // frame layout
    // ****************
    localparam logic [7:0]  START_DELIM      = 8'h7E;
    localparam logic [7:0]  TYPE_CMD_RESP    = 8'h88;
    localparam logic [7:0]  TYPE_MODEM_STAT  = 8'h8A;
    localparam logic [15:0] LEN_MODEM_STAT   = 16'h0002;
    localparam logic [15:0] LEN_CMD_FIXED    = 16'h0005;
    localparam logic [7:0]  CSUM_BASE        = 8'hFF;
    localparam logic [1:0]  CMD_BODY_LAST    = 2'h3;
    localparam logic [1:0]  MODEM_BODY_LAST  = 2'h0;
    localparam logic [7:0]  SUPPRESS_ID      = 8'h00;

    // ****************
    // command status codes
    // ****************
    localparam logic [7:0]  CMD_OK           = 8'h00;
    localparam logic [7:0]  CMD_ERROR        = 8'h01;
    localparam logic [7:0]  CMD_BAD_CMD      = 8'h02;
    localparam logic [7:0]  CMD_BAD_PARAM    = 8'h03;
    localparam logic [7:0]  CMD_TX_FAIL      = 8'h04;

    // ****************
    // modem status codes and event slots
    // ****************
    localparam logic [7:0]  MS_HW_RESET      = 8'h00;
    localparam logic [7:0]  MS_WATCHDOG      = 8'h01;
    localparam logic [7:0]  MS_JOINED        = 8'h02;
    localparam logic [7:0]  MS_DISASSOC      = 8'h03;
    localparam logic [7:0]  MS_COORD_START   = 8'h06;
    localparam logic [7:0]  MS_KEY_UPDATE    = 8'h07;
    localparam logic [7:0]  MS_SUPPLY_LIMIT  = 8'h0D;
    localparam logic [7:0]  MS_CFG_IN_JOIN   = 8'h11;
    localparam logic [7:0]  MS_STACK_ERR     = 8'h80;

    localparam int          EV_COUNT         = 9;
    localparam logic [8:0]  EV_RESET_VALUE   = 9'h001;

    // ****************
    // buffering
    // ****************
    localparam int          BYTE_W           = 8;
    localparam int          DATA_FIFO_DEPTH  = 8;

    typedef enum logic [3:0] {
        S_IDLE, S_DELIM, S_LEN_HI, S_LEN_LO, S_TYPE, S_BODY, S_DATA, S_CSUM, S_DRAIN
    } build_state_t;

endpackage

// >>> design/byte_fifo.sv
/*
 * first-in first-out buffer with valid/ready on both sides.
 * assumes depth is a power of two; one clock, synchronous reset.
 */
`timescale 1ns/1ps
module byte_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    // clock and reset
    input  wire logic             sys_clk,
    input  wire logic             rst,
    // fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);

    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_bad
        $error("byte_fifo depth must be a power of two of at least 2");
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr, next_wr_ptr;
    logic [AW-1:0]    rd_ptr, next_rd_ptr;
    logic [AW:0]      count, next_count;
    logic             push, pop;

    assign in_ready  = (count != DEPTH[AW:0]);
    assign out_valid = (count != '0);
    assign out_data  = mem[rd_ptr];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb begin
        next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
        next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
        next_count  = count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count  <= next_count;
        end
    end

    // storage is not reset; empty flag keeps stale words from being seen
    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

endmodule

// >>> design/frame_checksum.sv
/*
 * running frame checksum: complement of the low byte of a byte sum.
 * assumes the caller clears it before the first summed byte of a frame.
 */
`timescale 1ns/1ps
module frame_checksum (
    // clock and reset
    input  wire logic       sys_clk,
    input  wire logic       rst,
    // byte feed
    input  wire logic       sum_clear,
    input  wire logic       sum_add,
    input  wire logic [7:0] sum_byte,
    // result
    output logic [7:0]      csum
);
    import frame_pkg::*;

    logic [7:0] sum, next_sum;

    always_comb begin
        next_sum = sum;
        if (sum_clear) begin
            next_sum = 8'h00;
        end else if (sum_add) begin
            next_sum = sum + sum_byte;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            sum <= 8'h00;
        end else begin
            sum <= next_sum;
        end
    end

    assign csum = CSUM_BASE - sum; // R2

endmodule

// >>> design/api_response_frame_builder.sv
/*
 * builds command-response and modem-status frames as a byte stream for the
 * serial port toward the host; command data bytes pass through a fifo.
 * assumes event inputs and requests come from logic on sys_clk, and that a
 * uart transmitter downstream takes bytes with tx_valid/tx_ready.
 */
// Overview of operation
// R1 - delimiter, then sixteen-bit length, high byte first
// R2 - last byte is 0xFF minus byte sum
// R3 - command answers carry type 0x88
// R4 - one request may yield several consecutive frames
// R5 - frame identifier echoed at offset four
// R6 - identifier zero suppresses the command answer
// R7 - two command name characters echoed back
// R8 - status code byte follows the name
// R9 - query data follows status; writes carry none
// R10 - modem status frames: type 0x8A, length two
// R11 - reset, watchdog, join, disassociate, coordinator codes
// R12 - key update code 7; stack errors 0x80+
// R13 - config-during-join 0x11, supply limit 0x0D
// R14 - host tolerates unknown modem status codes
// R15 - host drops bad-checksum frames, resynchronises
`timescale 1ns/1ps
module api_response_frame_builder
    import frame_pkg::*;
#(
    parameter int FIFO_DEPTH = frame_pkg::DATA_FIFO_DEPTH
) (
    // clock and reset
    input  wire logic                        sys_clk,
    input  wire logic                        rst,
    // command answer request
    input  wire logic                        cmd_valid,
    output logic                             cmd_ready,
    input  wire logic [7:0]                  cmd_frame_id,
    input  wire logic [7:0]                  cmd_name_hi,
    input  wire logic [7:0]                  cmd_name_lo,
    input  wire logic [7:0]                  cmd_status,
    input  wire logic [7:0]                  cmd_data_count,
    input  wire logic                        cmd_more,
    // command data bytes
    input  wire logic                        data_valid,
    output logic                             data_ready,
    input  wire logic [frame_pkg::BYTE_W-1:0] data_byte,
    // modem events, one-cycle pulses
    input  wire logic                        ev_watchdog,
    input  wire logic                        ev_joined,
    input  wire logic                        ev_disassoc,
    input  wire logic                        ev_coord_start,
    input  wire logic                        ev_key_update,
    input  wire logic                        ev_supply_limit,
    input  wire logic                        ev_cfg_in_join,
    input  wire logic                        ev_stack_err,
    input  wire logic [6:0]                  stack_err_code,
    // byte stream toward the serial port
    output logic                             tx_valid,
    input  wire logic                        tx_ready,
    output logic [7:0]                       tx_byte,
    output logic                             tx_last
);

    // ****************
    // helpers
    // ****************
    // lowest pending slot wins; slot 0 is the power-up report
    function automatic logic [3:0] first_pending(input logic [EV_COUNT-1:0] p);
        logic [3:0] r;
        r = 4'hF;
        for (int i = EV_COUNT - 1; i >= 0; i--) begin
            if (p[i]) begin
                r = i[3:0];
            end
        end
        return r;
    endfunction

    function automatic logic [7:0] slot_code(input logic [3:0] s, input logic [6:0] err);
        logic [7:0] c;
        unique case (s)
            4'h0:    c = MS_HW_RESET;     // R11
            4'h1:    c = MS_WATCHDOG;     // R11
            4'h2:    c = MS_JOINED;       // R11
            4'h3:    c = MS_DISASSOC;     // R11
            4'h4:    c = MS_COORD_START;  // R11
            4'h5:    c = MS_KEY_UPDATE;   // R12
            4'h6:    c = MS_SUPPLY_LIMIT; // R13
            4'h7:    c = MS_CFG_IN_JOIN;  // R13
            4'h8:    c = MS_STACK_ERR | {1'b0, err}; // R12
            default: c = MS_HW_RESET;
        endcase
        return c;
    endfunction

    // ****************
    // state
    // ****************
    build_state_t          state, next_state;
    logic                  is_cmd, next_is_cmd;
    logic                  burst, next_burst;
    logic [1:0]            idx, next_idx;
    logic [7:0]            remain, next_remain;
    logic [15:0]           len, next_len;
    logic [7:0]            f_id, next_f_id;
    logic [7:0]            f_hi, next_f_hi;
    logic [7:0]            f_lo, next_f_lo;
    logic [7:0]            f_stat, next_f_stat;
    logic [EV_COUNT-1:0]   pending, next_pending;
    logic [6:0]            err_code, next_err_code;
    logic                  next_tx_valid;
    logic [7:0]            next_tx_byte;
    logic                  next_tx_last;

    logic                  slot_free;
    logic                  emit;
    logic [7:0]            emit_byte;
    logic                  emit_last;
    logic                  sum_add;
    logic                  sum_clear;
    logic [7:0]            csum;
    logic [EV_COUNT-1:0]   ev_vec;
    logic [EV_COUNT-1:0]   clr_mask;
    logic [3:0]            slot;
    logic                  fifo_valid;
    logic                  fifo_pop;
    logic [7:0]            fifo_byte;

    assign slot_free = !tx_valid || tx_ready;
    assign ev_vec    = {ev_stack_err, ev_cfg_in_join, ev_supply_limit, ev_key_update,
                        ev_coord_start, ev_disassoc, ev_joined, ev_watchdog, 1'b0};
    assign slot      = first_pending(pending);

    // ****************
    // data buffer and checksum
    // ****************
    // data_ready drops when full, stalling the data source
    byte_fifo #(
        .WIDTH (BYTE_W),
        .DEPTH (FIFO_DEPTH)
    ) u_data_fifo (
        .sys_clk   (sys_clk),
        .rst       (rst),
        .in_valid  (data_valid),
        .in_ready  (data_ready),
        .in_data   (data_byte),
        .out_valid (fifo_valid),
        .out_ready (fifo_pop),
        .out_data  (fifo_byte)
    );

    frame_checksum u_csum (
        .sys_clk   (sys_clk),
        .rst       (rst),
        .sum_clear (sum_clear),
        .sum_add   (sum_add),
        .sum_byte  (emit_byte),
        .csum      (csum)
    );

    // ****************
    // frame sequencer
    // ****************
    always_comb begin
        next_state    = state;
        next_is_cmd   = is_cmd;
        next_burst    = burst;
        next_idx      = idx;
        next_remain   = remain;
        next_len      = len;
        next_f_id     = f_id;
        next_f_hi     = f_hi;
        next_f_lo     = f_lo;
        next_f_stat   = f_stat;
        next_err_code = ev_stack_err ? stack_err_code : err_code;
        clr_mask      = '0;
        cmd_ready     = 1'b0;
        fifo_pop      = 1'b0;
        emit          = 1'b0;
        emit_byte     = 8'h00;
        emit_last     = 1'b0;
        sum_add       = 1'b0;
        sum_clear     = 1'b0;
        unique case (state)
            S_IDLE: begin
                // a multi-frame answer holds off status reports until done
                if (pending != '0 && !burst) begin
                    next_is_cmd = 1'b0;
                    next_f_stat = slot_code(slot, err_code);
                    next_len    = LEN_MODEM_STAT; // R10
                    clr_mask[slot] = 1'b1;
                    next_state  = S_DELIM;
                end else if (cmd_valid) begin
                    cmd_ready   = 1'b1;
                    next_is_cmd = 1'b1;
                    next_burst  = cmd_more; // R4
                    next_f_id   = cmd_frame_id;
                    next_f_hi   = cmd_name_hi;
                    next_f_lo   = cmd_name_lo;
                    next_f_stat = cmd_status;
                    next_remain = cmd_data_count;
                    next_len    = LEN_CMD_FIXED + {8'h00, cmd_data_count}; // R9
                    if (cmd_frame_id == SUPPRESS_ID) begin
                        // data still has to leave the buffer
                        next_state = (cmd_data_count == 8'h00) ? S_IDLE : S_DRAIN; // R6
                    end else begin
                        next_state = S_DELIM;
                    end
                end
            end
            S_DELIM: begin
                if (slot_free) begin
                    emit       = 1'b1;
                    emit_byte  = START_DELIM; // R1
                    sum_clear  = 1'b1;
                    next_state = S_LEN_HI;
                end
            end
            S_LEN_HI: begin
                if (slot_free) begin
                    emit       = 1'b1;
                    emit_byte  = len[15:8]; // R1
                    next_state = S_LEN_LO;
                end
            end
            S_LEN_LO: begin
                if (slot_free) begin
                    emit       = 1'b1;
                    emit_byte  = len[7:0]; // R1
                    next_state = S_TYPE;
                end
            end
            S_TYPE: begin
                if (slot_free) begin
                    emit       = 1'b1;
                    sum_add    = 1'b1;
                    emit_byte  = is_cmd ? TYPE_CMD_RESP : TYPE_MODEM_STAT; // R3 R10
                    next_idx   = 2'h0;
                    next_state = S_BODY;
                end
            end
            S_BODY: begin
                if (slot_free) begin
                    emit    = 1'b1;
                    sum_add = 1'b1;
                    if (!is_cmd) begin
                        emit_byte = f_stat; // R10
                    end else begin
                        unique case (idx)
                            2'h0: emit_byte = f_id;   // R5
                            2'h1: emit_byte = f_hi;   // R7
                            2'h2: emit_byte = f_lo;   // R7
                            2'h3: emit_byte = f_stat; // R8
                        endcase
                    end
                    next_idx = idx + 2'h1;
                    if (idx == (is_cmd ? CMD_BODY_LAST : MODEM_BODY_LAST)) begin
                        next_state = (is_cmd && remain != 8'h00) ? S_DATA : S_CSUM; // R9
                    end
                end
            end
            S_DATA: begin
                if (slot_free && fifo_valid) begin
                    emit        = 1'b1;
                    sum_add     = 1'b1;
                    fifo_pop    = 1'b1;
                    emit_byte   = fifo_byte; // R9
                    next_remain = remain - 8'h01;
                    if (remain == 8'h01) begin
                        next_state = S_CSUM;
                    end
                end
            end
            S_CSUM: begin
                if (slot_free) begin
                    emit       = 1'b1;
                    emit_last  = 1'b1;
                    emit_byte  = csum; // R2
                    next_state = S_IDLE;
                end
            end
            S_DRAIN: begin
                fifo_pop = fifo_valid; // R6
                if (fifo_valid) begin
                    next_remain = remain - 8'h01;
                    if (remain == 8'h01) begin
                        next_state = S_IDLE;
                    end
                end
            end
        endcase
        // an event in the same cycle as its clear stays pending
        next_pending = (pending & ~clr_mask) | ev_vec; // R11 R12 R13
        next_tx_valid = emit ? 1'b1 : (tx_ready ? 1'b0 : tx_valid);
        next_tx_byte  = emit ? emit_byte : tx_byte;
        next_tx_last  = emit ? emit_last : tx_last;
    end

    // the power-up report is queued by reset itself
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state    <= S_IDLE;
            is_cmd   <= 1'b0;
            burst    <= 1'b0;
            idx      <= 2'h0;
            remain   <= 8'h00;
            len      <= 16'h0000;
            f_id     <= 8'h00;
            f_hi     <= 8'h00;
            f_lo     <= 8'h00;
            f_stat   <= 8'h00;
            pending  <= EV_RESET_VALUE; // R11
            err_code <= 7'h00;
            tx_valid <= 1'b0;
            tx_byte  <= 8'h00;
            tx_last  <= 1'b0;
        end else begin
            state    <= next_state;
            is_cmd   <= next_is_cmd;
            burst    <= next_burst;
            idx      <= next_idx;
            remain   <= next_remain;
            len      <= next_len;
            f_id     <= next_f_id;
            f_hi     <= next_f_hi;
            f_lo     <= next_f_lo;
            f_stat   <= next_f_stat;
            pending  <= next_pending;
            err_code <= next_err_code;
            tx_valid <= next_tx_valid;
            tx_byte  <= next_tx_byte;
            tx_last  <= next_tx_last;
        end
    end

endmodule

// >>> tb/frame_checker.sv
/*
 * checker for the response frame builder: layout, checksum, echoed fields.
 * assumes it is bound to the builder and sees only its ports.
 */
`timescale 1ns/1ps
module frame_checker (
    // clock and reset
    input wire logic       sys_clk,
    input wire logic       rst,
    // command side
    input wire logic       cmd_valid,
    input wire logic       cmd_ready,
    input wire logic [7:0] cmd_frame_id,
    input wire logic [7:0] cmd_name_hi,
    input wire logic [7:0] cmd_name_lo,
    input wire logic [7:0] cmd_status,
    input wire logic [7:0] cmd_data_count,
    // byte stream
    input wire logic       tx_valid,
    input wire logic       tx_ready,
    input wire logic [7:0] tx_byte,
    input wire logic       tx_last
);
    // ****************
    // frame tracking
    // ****************
    logic [7:0]  idx, sum, ftype, id_q, hi_q, lo_q, st_q, cnt_q;
    logic [15:0] len;
    logic        take;
    assign take = cmd_valid && cmd_ready;
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            idx   <= 8'h00;
            sum   <= 8'h00;
            ftype <= 8'h00;
            len   <= 16'h0000;
        end else if (tx_valid && tx_ready) begin
            idx <= tx_last ? 8'h00 : idx + 8'h01;
            sum <= (idx < 8'h03) ? 8'h00 : sum + tx_byte;
            if (idx == 8'h01) len[15:8] <= tx_byte;
            if (idx == 8'h02) len[7:0] <= tx_byte;
            if (idx == 8'h03) ftype <= tx_byte;
        end
    end
    // fields kept at take; the frame they feed always starts after it
    always_ff @(posedge sys_clk) begin
        if (take) begin
            id_q  <= cmd_frame_id;
            hi_q  <= cmd_name_hi;
            lo_q  <= cmd_name_lo;
            st_q  <= cmd_status;
            cnt_q <= cmd_data_count;
        end
    end
    default clocking dc @(posedge sys_clk); endclocking
    default disable iff (rst);
    start_delim_a: assert property (tx_valid && idx == 8'h00 |-> tx_byte == 8'h7E)
        else $error("frame does not open with delimiter");
    frame_length_a: assert property (tx_valid && tx_last |-> {8'h00, idx} == len + 16'h0003)
        else $error("length field does not match frame");
    checksum_a: assert property (tx_valid && tx_last |-> tx_byte == 8'hFF - sum)
        else $error("bad checksum byte");
    answer_start_a: assert property (take && cmd_frame_id != 8'h00 |-> ##2 tx_valid &&
        (tx_byte == 8'h7E || tx_last)) else $error("answer frame late");
    frame_type_a: assert property (tx_valid && idx == 8'h03 |-> tx_byte inside {8'h88, 8'h8A})
        else $error("unexpected frame type");
    modem_len_a: assert property (tx_valid && idx == 8'h03 && tx_byte == 8'h8A |-> len == 16'h0002)
        else $error("status frame length wrong");
    cmd_len_a: assert property (tx_valid && idx == 8'h03 && tx_byte == 8'h88 |->
        len == 16'h0005 + {8'h00, cnt_q}) else $error("answer length wrong");
    id_echo_a: assert property (tx_valid && idx == 8'h04 && ftype == 8'h88 |-> tx_byte == id_q)
        else $error("frame id not echoed");
    name_echo_a: assert property (tx_valid && ftype == 8'h88 && idx inside {8'h05, 8'h06} |->
        tx_byte == (idx == 8'h05 ? hi_q : lo_q)) else $error("command name not echoed");
    status_byte_a: assert property (tx_valid && idx == 8'h07 && ftype == 8'h88 |-> tx_byte == st_q)
        else $error("status byte wrong");
    suppress_id_a: assert property (take && cmd_frame_id == 8'h00 |=> (!tx_valid || tx_last) [*2])
        else $error("answer sent for id zero");
endmodule
bind api_response_frame_builder frame_checker chk (.*);

// >>> tb/host_model.sv
/*
 * host on the serial side: takes bytes, keeps whole frames whose checksum holds.
 * assumes one byte per handshake; slow makes it stall every other cycle.
 */
`timescale 1ns/1ps
module host_model (
    // clock and reset
    input  wire logic       sys_clk,
    input  wire logic       rst,
    // byte stream from the builder
    input  wire logic       tx_valid,
    input  wire logic [7:0] tx_byte,
    input  wire logic       tx_last,
    output logic            tx_ready,
    // stall control
    input  wire logic       slow
);
    // ****************
    // frame capture
    // ****************
    logic [7:0] cur[$];
    logic [7:0] got[$];
    logic [7:0] s;
    int         frames = 0;
    int         bad = 0;
    logic       phase = 1'b0;
    always @(posedge sys_clk) begin
        phase <= ~phase;
        tx_ready <= #2 !rst && (!slow || phase);
        if (!rst && tx_valid && tx_ready) begin
            // bytes before a delimiter are skipped, so a broken frame resyncs
            if (cur.size() > 0 || tx_byte == 8'h7E) cur.push_back(tx_byte);
            if (tx_last) begin
                s = 8'h00;
                foreach (cur[i]) if (i >= 3) s += cur[i];
                // status codes are not screened, unknown ones pass through
                if (s == 8'hFF) begin
                    got = {got, cur};
                    frames++;
                end else bad++;
                cur.delete();
            end
        end
    end
endmodule

// >>> tb/api_response_frame_builder_tb.sv
/*
 * self-checking bench for the response frame builder.
 * assumes the host model on the byte stream and the bound frame checker.
 */
`timescale 1ns/1ps
module api_response_frame_builder_tb;
    import frame_pkg::*;
    logic       sys_clk, rst, cmd_valid, cmd_ready, cmd_more, data_valid, data_ready;
    logic       tx_valid, tx_ready, tx_last, slow;
    logic [7:0] cmd_frame_id, cmd_name_hi, cmd_name_lo, cmd_status, cmd_data_count;
    logic [7:0] data_byte, tx_byte, ev;
    logic [6:0] stack_err_code;
    int         failures = 0;
    int         tests_run = 0;
    int         seen = 0;
    api_response_frame_builder dut (.*, .ev_watchdog(ev[0]), .ev_joined(ev[1]),
        .ev_disassoc(ev[2]), .ev_coord_start(ev[3]), .ev_key_update(ev[4]),
        .ev_supply_limit(ev[5]), .ev_cfg_in_join(ev[6]), .ev_stack_err(ev[7]));
    host_model host (.*);
    // ****************
    // shared tasks
    // ****************
    task automatic check(input string what, input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic conclude();
        check("bad frames", 8'(host.bad), 8'h00);
        $display("checks %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // lengths stay under 256 here, so the high length byte is zero
    task automatic expect_frame(input logic [7:0] typ, input logic [7:0] body[$]);
        logic [7:0] f[$], s;
        f = {START_DELIM, 8'h00, 8'(body.size() + 1), typ, body};
        s = typ;
        foreach (body[i]) s += body[i];
        f.push_back(CSUM_BASE - s);
        // a frame or handshake that never comes is left to the watchdog
        while (host.frames <= seen) @(posedge sys_clk);
        #2;
        seen++;
        foreach (f[i]) check("frame byte", host.got.pop_front(), f[i]);
    endtask
    task automatic send_cmd(input logic [7:0] id, st, cnt, input logic more);
        @(posedge sys_clk);
        #2;
        cmd_valid = 1'b1;
        {cmd_frame_id, cmd_status, cmd_data_count, cmd_more} = {id, st, cnt, more};
        do @(negedge sys_clk); while (cmd_ready !== 1'b1);
        @(posedge sys_clk);
        #2;
        cmd_valid = 1'b0;
    endtask
    task automatic push(input logic [7:0] b);
        @(posedge sys_clk);
        #2;
        data_valid = 1'b1;
        data_byte = b;
        do @(negedge sys_clk); while (data_ready !== 1'b1);
        @(posedge sys_clk);
        #2;
        data_valid = 1'b0;
    endtask
    task automatic ev_pulse(input int i);
        @(posedge sys_clk);
        #2;
        ev = 8'h01 << i;
        @(posedge sys_clk);
        #2;
        ev = 8'h00;
    endtask
    // ****************
    // scenarios
    // ****************
    task automatic t_powerup();
        expect_frame(TYPE_MODEM_STAT, {MS_HW_RESET});
        $display("test powerup done");
    endtask
    task automatic t_write();
        slow = 1'b1;
        send_cmd(8'h01, CMD_OK, 8'h00, 1'b0);
        expect_frame(TYPE_CMD_RESP, {8'h01, 8'h42, 8'h44, 8'h00});
        slow = 1'b0;
        $display("test write done");
    endtask
    task automatic t_full_query();
        for (int i = 0; i < 8; i++) push(8'hA0 + 8'(i));
        slow = 1'b1;
        @(negedge sys_clk);
        check("fifo full", {7'h00, data_ready}, 8'h00);
        send_cmd(8'h07, CMD_OK, 8'h08, 1'b0);
        expect_frame(TYPE_CMD_RESP, {8'h07, 8'h42, 8'h44, 8'h00, 8'hA0, 8'hA1,
            8'hA2, 8'hA3, 8'hA4, 8'hA5, 8'hA6, 8'hA7});
        check("fifo drained", {7'h00, data_ready}, 8'h01);
        slow = 1'b0;
        $display("test full query done");
    endtask
    task automatic t_burst();
        for (int i = 0; i < 5; i++) begin
            send_cmd(8'h10 + 8'(i), 8'(i), 8'h00, i < 4);
            if (i == 0) ev_pulse(1);
        end
        for (int i = 0; i < 5; i++) begin
            expect_frame(TYPE_CMD_RESP, {8'h10 + 8'(i), 8'h42, 8'h44, 8'(i)});
        end
        expect_frame(TYPE_MODEM_STAT, {MS_JOINED});
        $display("test burst done");
    endtask
    task automatic t_suppress();
        push(8'h55);
        push(8'h66);
        send_cmd(SUPPRESS_ID, CMD_OK, 8'h02, 1'b0);
        push(8'h77);
        {cmd_name_hi, cmd_name_lo} = 16'h4E44;
        send_cmd(8'h04, CMD_BAD_PARAM, 8'h01, 1'b0);
        expect_frame(TYPE_CMD_RESP, {8'h04, 8'h4E, 8'h44, 8'h03, 8'h77});
        $display("test suppress done");
    endtask
    task automatic t_events();
        logic [7:0] codes[8];
        codes = '{8'h01, 8'h02, 8'h03, 8'h06, 8'h07, 8'h0D, 8'h11, 8'hAA};
        for (int i = 0; i < 8; i++) begin
            ev_pulse(i);
            expect_frame(TYPE_MODEM_STAT, {codes[i]});
        end
        $display("test events done");
    endtask
    // ****************
    // clock, run, watchdog
    // ****************
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    initial begin
        repeat (6000) @(posedge sys_clk);
        failures++;
        conclude();
    end
    initial begin
        rst = 1'b1;
        {cmd_valid, cmd_more, data_valid, slow} = 4'h0;
        {cmd_frame_id, cmd_status, cmd_data_count, data_byte, ev} = 40'h0;
        cmd_name_hi = 8'h42;
        cmd_name_lo = 8'h44;
        stack_err_code = 7'h2A;
        repeat (2) @(posedge sys_clk);
        #2;
        rst = 1'b0;
        t_powerup();
        t_write();
        t_full_query();
        t_burst();
        t_suppress();
        t_events();
        conclude();
    end
endmodule
